// file: rtl/svc_res_pkg.sv
// Package with types and constants for the service resolution stage.
package svc_res_pkg;

  localparam int SVC_W = 10;
  localparam int PORT_N = 11;
  localparam int POL_W = 10;
  localparam int STAT_W = 11;
  localparam int COS_W = 3;
  localparam int PRIO_W = 3;
  localparam int PT_W = 4;
  localparam int AGGR_W = 4;
  localparam int FTYPE_W = 3;
  localparam int FADDR_W = 12;
  localparam int IRQ_N = 4;
  localparam int COS_N = 8;

  localparam logic [SVC_W-1:0] NO_SERVICE = 10'h000;
  localparam logic [FTYPE_W-1:0] FTYPE_MULTICAST_INDEX = 3'h3;
  localparam logic [FTYPE_W-1:0] FTYPE_FLOOD = 3'h7;

  localparam int IRQ_CLS_HIT = 0;
  localparam int IRQ_PORT_LRN = 1;
  localparam int IRQ_FID_LRN = 2;
  localparam int IRQ_LRN_DONE = 3;
  localparam logic [IRQ_N-1:0] IRQ_RESET = 4'h0;

  // Forwarding decision kinds produced toward the forwarding stage.
  typedef enum logic [2:0]
  {
    FWD_DMAC = 3'b001,
    FWD_FLOOD = 3'b010,
    FWD_MCIDX = 3'b100
  } fwd_kind_t;

  // One service table entry.
  typedef struct packed
  {
    logic [PORT_N-1:0] port_mask;
    logic service_mask_replace;
    logic source_filter_disable;
    logic aggregation_override;
    logic [AGGR_W-1:0] aggregation_forced_value;
    logic service_forwarding_enable;
    logic dest_address_forwarding_enable;
    logic service_source_interface_enable;
    logic [FTYPE_W-1:0] fwd_type;
    logic [FADDR_W-1:0] fwd_addr;
    logic [POL_W-1:0] policer_base;
    logic [POL_W-1:0] bundle_policer_index;
    logic flood_policer_override;
    logic [POL_W-1:0] flood_policer_index;
    logic [PT_W-1:0] policing_pipeline_point;
    logic [STAT_W-1:0] stat_base;
  } svc_entry_t;

  // Per-frame request from the classifier.
  typedef struct packed
  {
    logic [SVC_W-1:0] service_index;
    logic [COS_W-1:0] class_of_service_id;
    logic [PRIO_W-1:0] internal_priority;
    logic [PORT_N-1:0] vlan_mask;
    logic [POL_W-1:0] vlan_flood_policer;
    logic [AGGR_W-1:0] aggr_computed;
    logic [FADDR_W-1:0] src_port;
    logic [POL_W-1:0] port_bundle_index;
    logic [POL_W-1:0] queue_policer_base;
    logic [PT_W-1:0] drop_point;
    logic dropped;
  } frame_req_t;

  // Per-frame result toward policing and forwarding.
  typedef struct packed
  {
    logic [PORT_N-1:0] port_mask;
    logic src_filter_ena;
    logic [AGGR_W-1:0] aggr_value;
    fwd_kind_t fwd_kind;
    logic [FADDR_W-1:0] multicast_index;
    logic learn_svc_if;
    logic [FTYPE_W-1:0] learn_type;
    logic [FADDR_W-1:0] learn_addr;
    logic service_policer_valid;
    logic [POL_W-1:0] service_policer;
    logic bundle_policer_valid;
    logic [POL_W-1:0] bundle_policer;
    logic [POL_W-1:0] flood_traffic_policer;
    logic stat_valid;
    logic [STAT_W-1:0] stat_index;
  } frame_res_t;

endpackage

// file: rtl/svc_irq_collect.sv
// Sticky interrupt collector for analyzer event sources.
`timescale 1ns/1ns
module svc_irq_collect
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [svc_res_pkg::IRQ_N-1:0] events,
  input wire logic [svc_res_pkg::IRQ_N-1:0] clear_w1c,
  input wire logic [svc_res_pkg::IRQ_N-1:0] enables,
  output logic [svc_res_pkg::IRQ_N-1:0] sticky_reg,
  output logic [svc_res_pkg::IRQ_N-1:0] ident_reg
);
  import svc_res_pkg::*;

  genvar i;
  generate
    for (i = 0; i < IRQ_N; i++)
    begin : g_src
      // A new event wins over a simultaneous software clear.
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          sticky_reg[i] <= 1'b0;
        else if (ce)
          sticky_reg[i] <= events[i] | (sticky_reg[i] & ~clear_w1c[i]);
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          ident_reg[i] <= 1'b0;
        else if (ce)
          ident_reg[i] <= (events[i] | (sticky_reg[i] & ~clear_w1c[i])) & enables[i];
      end
    end
  endgenerate

  a_ident_gated: assert property (@(posedge clk) disable iff (!resetn)
    ident_reg == (sticky_reg & $past(enables)) || !$past(ce))
    else $error("interrupt status differs from sticky and enable");

  a_event_sticks: assert property (@(posedge clk) disable iff (!resetn)
    (ce && events[0]) |=> sticky_reg[0])
    else $error("event did not set sticky bit");

  c_clear_hit: cover property (@(posedge clk) disable iff (!resetn)
    sticky_reg[0] && clear_w1c[0] && ce ##1 !sticky_reg[0]);
endmodule

// file: rtl/svc_cos_table.sv
// Per-service, per-class offset table for policer and statistics indexes.
`timescale 1ns/1ns
module svc_cos_table
(
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [svc_res_pkg::SVC_W-1:0] wr_svc,
  input wire logic [svc_res_pkg::COS_W-1:0] wr_cos,
  input wire logic [svc_res_pkg::POL_W-1:0] wr_pol_off,
  input wire logic [svc_res_pkg::STAT_W-1:0] wr_stat_off,
  input wire logic [svc_res_pkg::SVC_W-1:0] rd_svc,
  input wire logic [svc_res_pkg::COS_W-1:0] rd_cos,
  output logic [svc_res_pkg::POL_W-1:0] pol_off,
  output logic [svc_res_pkg::STAT_W-1:0] stat_off
);
  import svc_res_pkg::*;

  logic [POL_W-1:0] pol_mem [0:(1<<SVC_W)*COS_N-1];
  logic [STAT_W-1:0] stat_mem [0:(1<<SVC_W)*COS_N-1];

  // Combinational read so offsets line up with the entry read.
  assign pol_off = pol_mem[{rd_svc, rd_cos}];
  assign stat_off = stat_mem[{rd_svc, rd_cos}];

  always_ff @(posedge clk)
  begin
    if (ce && wr_en)
    begin
      pol_mem[{wr_svc, wr_cos}] <= wr_pol_off;
      stat_mem[{wr_svc, wr_cos}] <= wr_stat_off;
    end
  end
endmodule

// file: rtl/l2_service_resolution.sv
// Layer-2 service lookup and resolution stage with interrupt collector.
`timescale 1ns/1ns
module l2_service_resolution
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic SERVICE_LOOKUP_ENABLE,
  input wire logic QUEUE_DEFAULT_POLICER_ENABLE,
  input wire logic PORT_DEFAULT_BUNDLE_ENABLE,
  input wire logic ENTRY_WR,
  input wire logic [svc_res_pkg::SVC_W-1:0] ENTRY_WR_INDEX,
  input wire svc_res_pkg::svc_entry_t ENTRY_WR_DATA,
  input wire logic COS_WR,
  input wire logic [svc_res_pkg::SVC_W-1:0] COS_WR_INDEX,
  input wire logic [svc_res_pkg::COS_W-1:0] COS_WR_CLASS,
  input wire logic [svc_res_pkg::POL_W-1:0] COS_WR_POLICER_OFFSET,
  input wire logic [svc_res_pkg::STAT_W-1:0] COS_WR_STAT_OFFSET,
  input wire logic REQ_VALID,
  input wire svc_res_pkg::frame_req_t REQ,
  output svc_res_pkg::frame_res_t RES,
  output logic RES_VALID,
  input wire logic CLS_HIT,
  input wire logic CLS_HIT_IRQ_ACTION,
  input wire logic PORT_LEARN_OVER,
  input wire logic PORT_LEARN_IRQ_ENABLE,
  input wire logic FID_LEARN_OVER,
  input wire logic FID_LEARN_IRQ_ENABLE,
  input wire logic LEARN_ACCESS_DONE,
  input wire logic LEARN_ACCESS_IRQ_ENABLE,
  input wire logic [svc_res_pkg::IRQ_N-1:0] INTERRUPT_ENABLES,
  input wire logic [svc_res_pkg::IRQ_N-1:0] IRQ_CLEAR,
  output logic [svc_res_pkg::IRQ_N-1:0] IRQ_STICKY,
  output logic [svc_res_pkg::IRQ_N-1:0] INTERRUPT_CURRENT_STATUS
);
  import svc_res_pkg::*;

  // ----------------------------------------------------------------
  // Service table storage
  // ----------------------------------------------------------------
  svc_entry_t entry_mem [0:(1<<SVC_W)-1];
  svc_entry_t ent;
  logic [POL_W-1:0] pol_off;
  logic [STAT_W-1:0] stat_off;

  always_ff @(posedge CLK)
  begin
    if (CE && ENTRY_WR)
      entry_mem[ENTRY_WR_INDEX] <= ENTRY_WR_DATA;
  end

  assign ent = entry_mem[REQ.service_index];

  svc_cos_table u_cos
  (
    .clk(CLK),
    .ce(CE),
    .wr_en(COS_WR),
    .wr_svc(COS_WR_INDEX),
    .wr_cos(COS_WR_CLASS),
    .wr_pol_off(COS_WR_POLICER_OFFSET),
    .wr_stat_off(COS_WR_STAT_OFFSET),
    .rd_svc(REQ.service_index),
    .rd_cos(REQ.class_of_service_id),
    .pol_off(pol_off),
    .stat_off(stat_off)
  );

  // ----------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------
  logic svc_act;
  logic no_svc;
  logic pt_ok;
  frame_res_t res_next;

  // Service index 0 means no service; the table is used only when enabled.
  assign no_svc = (REQ.service_index == NO_SERVICE);
  assign svc_act = SERVICE_LOOKUP_ENABLE && !no_svc;
  // Frames dropped before the configured point get no service policer and are not counted; the bundle policer stays valid.
  assign pt_ok = !(REQ.dropped && (REQ.drop_point < ent.policing_pipeline_point));

  always_comb
  begin
    res_next = '0;
    res_next.port_mask = REQ.vlan_mask;
    res_next.src_filter_ena = 1'b1;
    res_next.aggr_value = REQ.aggr_computed;
    res_next.fwd_kind = FWD_DMAC;
    res_next.learn_type = '0;
    res_next.learn_addr = REQ.src_port;
    res_next.flood_traffic_policer = REQ.vlan_flood_policer;
    if (svc_act)
    begin
      if (ent.service_mask_replace)
        res_next.port_mask = ent.port_mask;
      else
        res_next.port_mask = REQ.vlan_mask & ent.port_mask;
      res_next.src_filter_ena = !ent.source_filter_disable;
      if (ent.aggregation_override)
        res_next.aggr_value = ent.aggregation_forced_value;
      if (ent.service_forwarding_enable && !ent.dest_address_forwarding_enable)
      begin
        if (ent.fwd_type == FTYPE_FLOOD)
          res_next.fwd_kind = FWD_FLOOD;
        else if (ent.fwd_type == FTYPE_MULTICAST_INDEX)
        begin
          res_next.fwd_kind = FWD_MCIDX;
          res_next.multicast_index = ent.fwd_addr;
        end
      end
      // keeps the two enables apart; learning does not check it.
      if (ent.service_source_interface_enable)
      begin
        res_next.learn_svc_if = 1'b1;
        res_next.learn_type = ent.fwd_type;
        res_next.learn_addr = ent.fwd_addr;
      end
      res_next.service_policer_valid = pt_ok;
      res_next.service_policer = POL_W'(ent.policer_base + pol_off);
      res_next.bundle_policer_valid = 1'b1;
      res_next.bundle_policer = ent.bundle_policer_index;
      if (ent.flood_policer_override)
        res_next.flood_traffic_policer = ent.flood_policer_index;
      res_next.stat_valid = pt_ok;
      res_next.stat_index = STAT_W'(ent.stat_base + stat_off);
    end
    else if (no_svc)
    begin
      if (QUEUE_DEFAULT_POLICER_ENABLE)
      begin
        res_next.service_policer_valid = 1'b1;
        res_next.service_policer =
          POL_W'(REQ.queue_policer_base + POL_W'(REQ.internal_priority));
      end
      if (PORT_DEFAULT_BUNDLE_ENABLE)
      begin
        res_next.bundle_policer_valid = 1'b1;
        res_next.bundle_policer = REQ.port_bundle_index;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      RES_VALID <= 1'b0;
    else if (CE)
      RES_VALID <= REQ_VALID;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      RES <= '{fwd_kind: FWD_DMAC, default: '0};
    else if (CE && REQ_VALID)
      RES <= res_next;
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic [IRQ_N-1:0] irq_ev;

  assign irq_ev[IRQ_CLS_HIT] = CLS_HIT && CLS_HIT_IRQ_ACTION;
  assign irq_ev[IRQ_PORT_LRN] = PORT_LEARN_OVER && PORT_LEARN_IRQ_ENABLE;
  assign irq_ev[IRQ_FID_LRN] = FID_LEARN_OVER && FID_LEARN_IRQ_ENABLE;
  assign irq_ev[IRQ_LRN_DONE] = LEARN_ACCESS_DONE && LEARN_ACCESS_IRQ_ENABLE;

  svc_irq_collect u_irq
  (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .events(irq_ev),
    .clear_w1c(IRQ_CLEAR),
    .enables(INTERRUPT_ENABLES),
    .sticky_reg(IRQ_STICKY),
    .ident_reg(INTERRUPT_CURRENT_STATUS)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_lookup_gate: assert property (CE && REQ_VALID && !SERVICE_LOOKUP_ENABLE |=>
    RES.port_mask == $past(REQ.vlan_mask) && RES.src_filter_ena)
    else $error("service settings applied with lookup disabled");

  a_lookup_quiet: assert property (CE && REQ_VALID && !svc_act |=>
    RES.fwd_kind == FWD_DMAC && !RES.learn_svc_if && !RES.stat_valid)
    else $error("service forwarding applied without an active service");

  a_disabled_service: assert property (CE && REQ_VALID && !no_svc
    && !SERVICE_LOOKUP_ENABLE |=> !RES.service_policer_valid && !RES.bundle_policer_valid)
    else $error("defaults applied with lookup disabled");

  a_mask_merge: assert property (CE && REQ_VALID && svc_act
    && !ent.service_mask_replace |=>
    RES.port_mask == ($past(REQ.vlan_mask) & $past(ent.port_mask)))
    else $error("service mask not ANDed with VLAN mask");

  a_mask_replace: assert property (CE && REQ_VALID && svc_act
    && ent.service_mask_replace |=> RES.port_mask == $past(ent.port_mask))
    else $error("service mask did not replace VLAN mask");

  a_src_filter: assert property (CE && REQ_VALID && svc_act
    && ent.source_filter_disable |=> !RES.src_filter_ena)
    else $error("source filter not disabled");

  a_src_filter_on: assert property (CE && REQ_VALID && svc_act
    && !ent.source_filter_disable |=> RES.src_filter_ena)
    else $error("source filter dropped without disable bit");

  a_aggr_force: assert property (CE && REQ_VALID && svc_act
    && ent.aggregation_override |=> RES.aggr_value == $past(ent.aggregation_forced_value))
    else $error("aggregation value not forced");

  a_aggr_normal: assert property (CE && REQ_VALID && svc_act
    && !ent.aggregation_override |=> RES.aggr_value == $past(REQ.aggr_computed))
    else $error("computed aggregation value not kept");

  a_svc_flood: assert property (CE && REQ_VALID && svc_act
    && ent.service_forwarding_enable && !ent.dest_address_forwarding_enable
    && ent.fwd_type == FTYPE_FLOOD |=> RES.fwd_kind == FWD_FLOOD)
    else $error("service flood decision missing");

  a_svc_mcidx: assert property (CE && REQ_VALID && svc_act
    && ent.service_forwarding_enable && !ent.dest_address_forwarding_enable
    && ent.fwd_type == FTYPE_MULTICAST_INDEX |=>
    RES.fwd_kind == FWD_MCIDX && RES.multicast_index == $past(ent.fwd_addr))
    else $error("multicast index decision wrong");

  a_dmac_kept: assert property (CE && REQ_VALID && svc_act
    && !(ent.service_forwarding_enable && !ent.dest_address_forwarding_enable)
    |=> RES.fwd_kind == FWD_DMAC)
    else $error("address lookup overruled without service forwarding");

  a_learn_if: assert property (CE && REQ_VALID && svc_act
    && ent.service_source_interface_enable |=>
    RES.learn_svc_if && RES.learn_addr == $past(ent.fwd_addr))
    else $error("learning interface not taken from service");

  a_learn_port: assert property (CE && REQ_VALID && svc_act
    && !ent.service_source_interface_enable |=>
    !RES.learn_svc_if && RES.learn_addr == $past(REQ.src_port))
    else $error("received port not used for learning");

  a_svc_policer: assert property (CE && REQ_VALID && svc_act |=>
    RES.service_policer == POL_W'($past(ent.policer_base) + $past(pol_off)))
    else $error("service policer index wrong");

  a_queue_default: assert property (CE && REQ_VALID && no_svc
    && QUEUE_DEFAULT_POLICER_ENABLE |=> RES.service_policer_valid && RES.service_policer ==
    POL_W'($past(REQ.queue_policer_base) + POL_W'($past(REQ.internal_priority))))
    else $error("queue default policer wrong");

  a_no_queue_def: assert property (CE && REQ_VALID && no_svc
    && !QUEUE_DEFAULT_POLICER_ENABLE |=> !RES.service_policer_valid && !RES.stat_valid)
    else $error("service policer valid without queue default");

  a_bundle_port: assert property (CE && REQ_VALID && no_svc
    && PORT_DEFAULT_BUNDLE_ENABLE |=> RES.bundle_policer == $past(REQ.port_bundle_index))
    else $error("port default bundle index wrong");

  a_no_port_def: assert property (CE && REQ_VALID && no_svc
    && !PORT_DEFAULT_BUNDLE_ENABLE |=> !RES.bundle_policer_valid)
    else $error("bundle policer valid without port default");

  a_bundle_entry: assert property (CE && REQ_VALID && svc_act |=>
    RES.bundle_policer_valid && RES.bundle_policer == $past(ent.bundle_policer_index))
    else $error("service bundle index wrong");

  a_flood_pol: assert property (CE && REQ_VALID && svc_act
    && ent.flood_policer_override |=>
    RES.flood_traffic_policer == $past(ent.flood_policer_index))
    else $error("flood policer override missing");

  a_flood_vlan: assert property (CE && REQ_VALID
    && !(svc_act && ent.flood_policer_override) |=>
    RES.flood_traffic_policer == $past(REQ.vlan_flood_policer))
    else $error("VLAN flood policer not kept");

  a_early_drop: assert property (CE && REQ_VALID && svc_act && !pt_ok |=>
    !RES.service_policer_valid && !RES.stat_valid)
    else $error("early drop was policed or counted");

  a_late_drop: assert property (CE && REQ_VALID && svc_act && pt_ok |=>
    RES.service_policer_valid && RES.stat_valid)
    else $error("frame kept past the point was not policed or counted");

  a_stat_index: assert property (CE && REQ_VALID && svc_act |=>
    RES.stat_index == STAT_W'($past(ent.stat_base) + $past(stat_off)))
    else $error("statistics index wrong");

  a_status_gate: assert property (CE |=>
    INTERRUPT_CURRENT_STATUS == (IRQ_STICKY & $past(INTERRUPT_ENABLES)))
    else $error("current status differs from sticky and enable");

  a_irq_sources: assert property (CE && CLS_HIT && CLS_HIT_IRQ_ACTION |=>
    IRQ_STICKY[IRQ_CLS_HIT])
    else $error("classification hit not raised");

  a_irq_refused: assert property (CE && !(CLS_HIT && CLS_HIT_IRQ_ACTION)
    && !IRQ_STICKY[IRQ_CLS_HIT] |=> !IRQ_STICKY[IRQ_CLS_HIT])
    else $error("classification hit raised without interrupt action");

  a_port_lrn: assert property (CE && PORT_LEARN_OVER && PORT_LEARN_IRQ_ENABLE |=>
    IRQ_STICKY[IRQ_PORT_LRN])
    else $error("port learn limit not raised");

  a_fid_lrn: assert property (CE && FID_LEARN_OVER && FID_LEARN_IRQ_ENABLE |=>
    IRQ_STICKY[IRQ_FID_LRN])
    else $error("identifier learn limit not raised");

  a_lrn_done: assert property (CE && LEARN_ACCESS_DONE && LEARN_ACCESS_IRQ_ENABLE |=>
    IRQ_STICKY[IRQ_LRN_DONE])
    else $error("access done not raised");

  c_svc_flood: cover property (CE && REQ_VALID && svc_act && ent.fwd_type == FTYPE_FLOOD);
  c_queue_def: cover property (CE && REQ_VALID && no_svc && QUEUE_DEFAULT_POLICER_ENABLE);
  c_early_drop: cover property (CE && REQ_VALID && svc_act && !pt_ok);
  c_mask_replace: cover property (CE && REQ_VALID && svc_act && ent.service_mask_replace);
endmodule

// file: tb/res_sink.sv
// Downstream stage model that takes every resolved frame result.
`timescale 1ns/1ns
module res_sink
  import svc_res_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic res_valid,
  input wire svc_res_pkg::frame_res_t res,
  output svc_res_pkg::frame_res_t last_reg,
  output logic [15:0] count_reg
);
  // ----------------------------------------
  // Capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= 16'h0000;
      last_reg <= '0;
    end
    else if (res_valid)
    begin
      count_reg <= count_reg + 16'h0001;
      last_reg <= res;
    end
  end
endmodule

// file: tb/l2_service_resolution_test.sv
// Self-checking testbench for the service resolution stage.
`timescale 1ns/1ns
module l2_service_resolution_test;
  import svc_res_pkg::*;
  logic CLK = 0, RESETN = 0, CE = 1, LKP = 0, QDEF = 0, PDEF = 0;
  logic ENTRY_WR = 0, COS_WR = 0, REQ_VALID = 0, RES_VALID;
  logic [SVC_W-1:0] ENTRY_WR_INDEX = '0, COS_WR_INDEX = '0;
  svc_entry_t ENTRY_WR_DATA = '0;
  logic [COS_W-1:0] COS_WR_CLASS = '0;
  logic [POL_W-1:0] COS_POL = '0;
  logic [STAT_W-1:0] COS_STAT = '0;
  frame_req_t REQ = '0;
  frame_res_t RES, last;
  logic [IRQ_N-1:0] ev = '0, en = '0, ien = '0, clr = '0, STICKY, STATUS;
  logic [15:0] seen;
  int n_errors = 0, check_count = 0, sent = 0;
  svc_entry_t e;
  frame_req_t r;
  initial forever #4 CLK = ~CLK;
  l2_service_resolution dut (.CLK(CLK), .RESETN(RESETN), .CE(CE),
    .SERVICE_LOOKUP_ENABLE(LKP), .QUEUE_DEFAULT_POLICER_ENABLE(QDEF),
    .PORT_DEFAULT_BUNDLE_ENABLE(PDEF), .ENTRY_WR(ENTRY_WR), .ENTRY_WR_INDEX(ENTRY_WR_INDEX),
    .ENTRY_WR_DATA(ENTRY_WR_DATA), .COS_WR(COS_WR), .COS_WR_INDEX(COS_WR_INDEX),
    .COS_WR_CLASS(COS_WR_CLASS), .COS_WR_POLICER_OFFSET(COS_POL),
    .COS_WR_STAT_OFFSET(COS_STAT), .REQ_VALID(REQ_VALID), .REQ(REQ), .RES(RES),
    .RES_VALID(RES_VALID), .CLS_HIT(ev[0]), .CLS_HIT_IRQ_ACTION(en[0]),
    .PORT_LEARN_OVER(ev[1]), .PORT_LEARN_IRQ_ENABLE(en[1]), .FID_LEARN_OVER(ev[2]),
    .FID_LEARN_IRQ_ENABLE(en[2]), .LEARN_ACCESS_DONE(ev[3]), .LEARN_ACCESS_IRQ_ENABLE(en[3]),
    .INTERRUPT_ENABLES(ien), .IRQ_CLEAR(clr), .IRQ_STICKY(STICKY),
    .INTERRUPT_CURRENT_STATUS(STATUS));
  res_sink sink (.clk(CLK), .resetn(RESETN), .res_valid(RES_VALID), .res(RES),
    .last_reg(last), .count_reg(seen));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_entry(input logic [SVC_W-1:0] i, input svc_entry_t d);
    @(posedge CLK);
    #1 ENTRY_WR = 1; ENTRY_WR_INDEX = i; ENTRY_WR_DATA = d;
    @(posedge CLK);
    #1 ENTRY_WR = 0;
  endtask
  task automatic wr_cos(input logic [SVC_W-1:0] i, input logic [COS_W-1:0] c,
    input logic [POL_W-1:0] p, input logic [STAT_W-1:0] s);
    @(posedge CLK);
    #1 COS_WR = 1; COS_WR_INDEX = i; COS_WR_CLASS = c; COS_POL = p; COS_STAT = s;
    @(posedge CLK);
    #1 COS_WR = 0;
  endtask
  // Sends one frame and leaves RES on the ports for the caller to compare.
  task automatic send(input frame_req_t q);
    @(posedge CLK);
    #1 REQ_VALID = 1; REQ = q;
    @(posedge CLK);
    #1 REQ_VALID = 0;
    sent++;
    chk("res_valid", 1, RES_VALID);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge CLK);
    #1 RESETN = 1;
    chk("sticky_rst", 0, STICKY);
    chk("res_rst", {1'b0, FWD_DMAC}, {RES_VALID, RES.fwd_kind});
    e = '0;
    e.port_mask = 11'h0f0; e.source_filter_disable = 1; e.aggregation_override = 1;
    e.aggregation_forced_value = 4'h9; e.service_forwarding_enable = 1;
    e.fwd_type = FTYPE_FLOOD; e.policer_base = 10'h020; e.bundle_policer_index = 10'h055;
    e.flood_policer_override = 1; e.flood_policer_index = 10'h077;
    e.policing_pipeline_point = 4'h5; e.stat_base = 11'h100;
    wr_entry(10'h005, e);
    e.service_mask_replace = 1; e.port_mask = 11'h003; e.source_filter_disable = 0;
    e.aggregation_override = 0; e.fwd_type = FTYPE_MULTICAST_INDEX; e.fwd_addr = 12'h02a;
    e.flood_policer_override = 0;
    wr_entry(10'h006, e);
    e.service_forwarding_enable = 0; e.service_source_interface_enable = 1;
    e.fwd_addr = 12'h0b0;
    wr_entry(10'h007, e);
    e.service_source_interface_enable = 0; e.service_forwarding_enable = 1;
    e.dest_address_forwarding_enable = 1; e.fwd_type = FTYPE_FLOOD;
    wr_entry(10'h008, e);
    wr_cos(10'h005, 3'h2, 10'h003, 11'h004);
    wr_cos(10'h006, 3'h2, 10'h001, 11'h002);
    wr_cos(10'h007, 3'h2, 10'h005, 11'h006);
    wr_cos(10'h008, 3'h2, 10'h000, 11'h000);
    r = '0;
    r.class_of_service_id = 3'h2; r.internal_priority = 3'h6; r.vlan_mask = 11'h3cc;
    r.vlan_flood_policer = 10'h111; r.aggr_computed = 4'h2; r.src_port = 12'h004;
    r.port_bundle_index = 10'h0aa; r.queue_policer_base = 10'h040; r.service_index = 10'h005;
    send(r);
    chk("lkp_off_mask", 11'h3cc, RES.port_mask);
    chk("lkp_off_pol", 0, RES.service_policer_valid);
    chk("lkp_off_fwd", FWD_DMAC, RES.fwd_kind);
    LKP = 1;
    send(r);
    chk("and_mask", 11'h0c0, RES.port_mask);
    chk("src_filter", 0, RES.src_filter_ena);
    chk("aggr_forced", 4'h9, RES.aggr_value);
    chk("fwd_flood", FWD_FLOOD, RES.fwd_kind);
    chk("svc_pol", {1'b1, 10'h023}, {RES.service_policer_valid, RES.service_policer});
    chk("bundle", {1'b1, 10'h055}, {RES.bundle_policer_valid, RES.bundle_policer});
    chk("flood_ovr", 10'h077, RES.flood_traffic_policer);
    chk("stat", {1'b1, 11'h104}, {RES.stat_valid, RES.stat_index});
    r.dropped = 1; r.drop_point = 4'h5;
    send(r);
    chk("drop_at_pt", 1, RES.stat_valid & RES.service_policer_valid);
    r.service_index = 10'h006; r.drop_point = 4'h4;
    send(r);
    chk("replace_mask", 11'h003, RES.port_mask);
    chk("src_filter_on", 1, RES.src_filter_ena);
    chk("aggr_norm", 4'h2, RES.aggr_value);
    chk("fwd_mc", {FWD_MCIDX, 12'h02a}, {RES.fwd_kind, RES.multicast_index});
    chk("flood_vlan", 10'h111, RES.flood_traffic_policer);
    chk("drop_early", 0, RES.stat_valid | RES.service_policer_valid);
    r.dropped = 0; r.service_index = 10'h007;
    send(r);
    chk("learn_if", {1'b1, 3'h3, 12'h0b0}, {RES.learn_svc_if, RES.learn_type, RES.learn_addr});
    chk("learn_fwd", FWD_DMAC, RES.fwd_kind);
    chk("learn_pol", {1'b1, 10'h025}, {RES.service_policer_valid, RES.service_policer});
    r.service_index = 10'h008;
    send(r);
    chk("dmac_kept", FWD_DMAC, RES.fwd_kind);
    r.service_index = NO_SERVICE;
    send(r);
    chk("no_def", 0, RES.service_policer_valid | RES.bundle_policer_valid);
    QDEF = 1; PDEF = 1;
    send(r);
    chk("q_def", {1'b1, 10'h046}, {RES.service_policer_valid, RES.service_policer});
    chk("p_def", {1'b1, 10'h0aa}, {RES.bundle_policer_valid, RES.bundle_policer});
    @(posedge CLK);
    #1 CE = 0; REQ_VALID = 1;
    @(posedge CLK);
    #1 chk("ce_hold", 0, RES_VALID);
    CE = 1; REQ_VALID = 0;
    #1 chk("sink_count", sent, seen);
    chk("sink_last", {1'b1, 10'h0aa}, {last.bundle_policer_valid, last.bundle_policer});
    for (int i = 0; i < IRQ_N; i++)
    begin
      @(posedge CLK);
      #1 ev = 4'h1 << i; en = 4'h0; ien = 4'hf;
      @(posedge CLK);
      #1 chk("irq_refused", 0, STICKY);
      en = 4'h1 << i;
      @(posedge CLK);
      #1 ev = 4'h0; en = 4'h0;
      chk("irq_sticky", 4'h1 << i, STICKY);
      repeat (2) @(posedge CLK);
      #1 chk("irq_status", 4'h1 << i, STATUS);
      ien = ~(4'h1 << i);
      repeat (2) @(posedge CLK);
      #1 chk("irq_masked", 0, STATUS);
      chk("irq_kept", 4'h1 << i, STICKY);
      clr = 4'h1 << i;
      @(posedge CLK);
      #1 clr = 4'h0;
      chk("irq_clear", 0, STICKY);
    end
    summarize();
  end
endmodule
